// [logic/mem_timing_map.vh]
`ifndef MEM_TIMING_MAP_VH
`define MEM_TIMING_MAP_VH

// register byte offsets
`define MTC_OFFSET      12'h000
`define STAT_OFFSET     12'h004

// control word reset and writable bits
`define MTC_RESET       32'h00000000
`define MTC_WMASK       32'hF8BBFFFF

// field positions
`define ROW_HOLD_MODE_SELECT_BIT        31
`define TRC_LSB         27
`define CAS_NEGATION_SELECT_BIT        23
`define TPC_LSB         19
`define RCD_LSB         16
`define TRWL_LSB        13
`define TRAS_LSB        10
`define BE_BIT          9
`define SZ_LSB          7
`define EXTENDED_MULTIPLEX_BIT_BIT      6
`define AMX_LSB         3
`define EDO_BIT         0

// timing bases in bus clock cycles
`define TRC_MULT        6'h03
`define CBR_BASE        6'h02
`define SDREF_BASE      6'h04
`define RCD_DRAM_BASE   6'h02
`define CAS_BASE        6'h01

// command codes
`define CMD_ACT         3'h0
`define CMD_RD          3'h1
`define CMD_WR          3'h2
`define CMD_PRE         3'h3
`define CMD_REF         3'h4

// transfer sizes
`define SIZE_8          3'h0
`define SIZE_16         3'h1
`define SIZE_32         3'h2
`define SIZE_64         3'h3
`define SIZE_BLOCK      3'h4

// bus width codes
`define SZ_64           2'h0
`define SZ_BAD          2'h1
`define SZ_16           2'h2
`define SZ_32           2'h3

`endif

// [logic/cycle_timer.v]
`timescale 1ns/1ns
`default_nettype none

module cycle_timer (
	input  wire       clk_in,   // bus clock
	input  wire       rst_in,   // sync reset
	input  wire       load_in,  // load new wait
	input  wire [5:0] value_in, // wait in cycles
	output wire [5:0] count_out, // cycles left
	output wire       zero_out  // wait elapsed
);

	reg [5:0] count_reg;

	// down counter, reload wins over decrement
	always @(posedge clk_in) begin
		if (rst_in)
			count_reg <= 6'h00;
		else if (load_in)
			count_reg <= value_in;
		else if (count_reg != 6'h00)
			count_reg <= count_reg - 6'h01;
	end

	assign count_out = count_reg;
	assign zero_out  = (count_reg == 6'h00);

endmodule

`default_nettype wire

// [logic/timing_decode.v]
`timescale 1ns/1ns
`default_nettype none
`include "mem_timing_map.vh"

module timing_decode (
	input  wire [31:0] ctrl_in,     // control word
	input  wire        sdram_in,    // sdram selected
	output wire [5:0]  ref_pre_out, // precharge after refresh
	output wire [5:0]  cas_neg_out, // cas negate cycles
	output wire [5:0]  pre_gap_out, // precharge to activate
	output wire [5:0]  rcd_out,     // activate to column
	output wire [5:0]  trwl_out,    // write to precharge
	output wire [5:0]  cbr_out,     // cbr ras width
	output wire [5:0]  sdref_out    // sdram refresh gap
);

	wire [2:0] trc_code;
	wire [2:0] tpc_code;
	wire [1:0] rcd_code;
	wire [2:0] trwl_code;
	wire [2:0] tras_code;

	assign trc_code  = ctrl_in[`TRC_LSB+2:`TRC_LSB];
	assign tpc_code  = ctrl_in[`TPC_LSB+2:`TPC_LSB];
	assign rcd_code  = ctrl_in[`RCD_LSB+1:`RCD_LSB];
	assign trwl_code = ctrl_in[`TRWL_LSB+2:`TRWL_LSB];
	assign tras_code = ctrl_in[`TRAS_LSB+2:`TRAS_LSB];

	// refresh precharge is three cycles per code step
	assign ref_pre_out = `TRC_MULT * {3'h0, trc_code};
	// cas_negation_select only matters on the dram side
	assign cas_neg_out = `CAS_BASE +
		{5'h00, ctrl_in[`CAS_NEGATION_SELECT_BIT] & ~sdram_in};
	// dram uses the code, sdram the code plus one
	assign pre_gap_out = {3'h0, tpc_code} + {5'h00, sdram_in};
	// dram 2..5, sdram code 1..3 gives 2..4
	assign rcd_out = sdram_in ? {4'h0, rcd_code} + 6'h01 :
		{4'h0, rcd_code} + `RCD_DRAM_BASE;
	// write recovery applies to sdram only
	assign trwl_out = sdram_in ?
		{3'h0, trwl_code} + 6'h01 : 6'h00;
	assign cbr_out   = {3'h0, tras_code} + `CBR_BASE;
	assign sdref_out = `SDREF_BASE + {3'h0, tras_code} +
		ref_pre_out;

endmodule

`default_nettype wire

// [logic/mem_timing_ctrl.v]
// Functional notes
// - refresh precharge equals three times code
// - reserved bits read zero, writes dropped
// - dram cas negated one or two cycles
// - dram ras precharge equals code cycles
// - sdram precharge gap is code plus one
// - dram ras to cas 2 to 5
// - sdram activate to command 2 to 4
// - sdram write blocks precharge 1 to 5
// - auto precharge write blocks activate longer
// - write delay ignored outside sdram
// - dram cbr ras width code plus two
// - sdram refresh gap four plus ras code plus refresh precharge
// - sdram always bursts
// - burst and edo pick dram mode
// - fast page bursts only certain sizes
// - size field sets memory bus width
// - dram column bits eight to twelve
// - bit 31 picks ras down mode
`timescale 1ns/1ns
`default_nettype none
`include "mem_timing_map.vh"

module mem_timing_ctrl (
	input  wire        clk_in,        // bus clock
	input  wire        rst_in,        // sync reset, high
	input  wire        psel_in,       // apb select
	input  wire        penable_in,    // apb enable
	input  wire        pwrite_in,     // apb write
	input  wire [11:0] paddr_in,      // apb byte address
	input  wire [31:0] pwdata_in,     // apb write data
	output reg  [31:0] prdata_out,    // apb read data
	output wire        pready_out,    // apb ready
	output wire        pslverr_out,   // apb error
	input  wire        sdram_sel_in,  // areas use sdram
	input  wire        cmd_valid_in,  // command request
	input  wire [2:0]  cmd_code_in,   // command code
	output wire        cmd_ready_out, // command taken
	input  wire [2:0]  xfer_size_in,  // next transfer size
	output reg         ras_out,       // row strobe active
	output reg         cas_out,       // column strobe active
	output reg         page_burst_out, // use page burst
	output reg  [1:0]  xfer_mode_out, // transfer mode
	output reg  [1:0]  bus_width_out, // memory bus width
	output reg  [3:0]  col_bits_out,  // column address bits
	output reg         cfg_error_out  // illegal setting
);

	// sequencer states, one-hot
	localparam ST_IDLE = 3'b001;
	localparam ST_OPEN = 3'b010;
	localparam ST_CBR  = 3'b100;

	// transfer modes
	localparam MODE_SINGLE = 2'h0;
	localparam MODE_PAGE   = 2'h1;
	localparam MODE_EDO    = 2'h2;
	localparam MODE_SDRAM  = 2'h3;

	reg  [31:0] ctrl_reg;
	reg  [31:0] ctrl_next;
	reg  [2:0]  state_reg;
	reg  [2:0]  state_next;
	reg         ras_next;
	reg         cas_next;
	reg         act_load;
	reg  [5:0]  act_value;
	reg         rw_load;
	reg  [5:0]  rw_value;
	reg         pre_load;
	reg  [5:0]  pre_value;
	reg         ready;
	reg  [31:0] rdata_next;

	wire        setup;
	wire        access;
	wire        hit_ctrl;
	wire        hit_stat;
	wire        wr_ctrl;
	wire        accept;
	wire        row_hold_mode_select;
	wire [1:0]  sz_code;
	wire [2:0]  amx_code;
	wire [1:0]  mode;
	wire [5:0]  ref_pre;
	wire [5:0]  cas_neg;
	wire [5:0]  pre_gap;
	wire [5:0]  rcd;
	wire [5:0]  trwl;
	wire [5:0]  cbr;
	wire [5:0]  sdref;
	wire [5:0]  act_count;
	wire [5:0]  rw_count;
	wire [5:0]  pre_count;
	wire        act_zero;
	wire        rw_zero;
	wire        pre_zero;

	// page burst decision for a transfer size
	function page_burst;
		input [1:0] m;
		input [1:0] w;
		input [2:0] s;
		begin
			case (m)
				MODE_SDRAM: page_burst = 1'b1;
				MODE_EDO:   page_burst = 1'b1;
				MODE_PAGE:  page_burst = (s == `SIZE_BLOCK) ||
					(s == `SIZE_64 && w != `SZ_64) ||
					(s == `SIZE_32 && w == `SZ_16);
				default:    page_burst = 1'b0;
			endcase
		end
	endfunction

	// field views of the control word
	assign row_hold_mode_select     = ctrl_reg[`ROW_HOLD_MODE_SELECT_BIT];
	assign sz_code  = ctrl_reg[`SZ_LSB+1:`SZ_LSB];
	assign amx_code = ctrl_reg[`AMX_LSB+2:`AMX_LSB];

	// dram mode from burst and edo bits
	assign mode = sdram_sel_in ? MODE_SDRAM :
		!ctrl_reg[`BE_BIT] ? MODE_SINGLE :
		ctrl_reg[`EDO_BIT] ? MODE_EDO : MODE_PAGE;

	timing_decode u_decode (
		.ctrl_in     (ctrl_reg),
		.sdram_in    (sdram_sel_in),
		.ref_pre_out (ref_pre),
		.cas_neg_out (cas_neg),
		.pre_gap_out (pre_gap),
		.rcd_out     (rcd),
		.trwl_out    (trwl),
		.cbr_out     (cbr),
		.sdref_out   (sdref)
	);

	// blocks activate and refresh
	cycle_timer u_act (
		.clk_in    (clk_in),
		.rst_in    (rst_in),
		.load_in   (act_load),
		.value_in  (act_value),
		.count_out (act_count),
		.zero_out  (act_zero)
	);

	// blocks column commands
	cycle_timer u_rw (
		.clk_in    (clk_in),
		.rst_in    (rst_in),
		.load_in   (rw_load),
		.value_in  (rw_value),
		.count_out (rw_count),
		.zero_out  (rw_zero)
	);

	// blocks precharge after write
	cycle_timer u_pre (
		.clk_in    (clk_in),
		.rst_in    (rst_in),
		.load_in   (pre_load),
		.value_in  (pre_value),
		.count_out (pre_count),
		.zero_out  (pre_zero)
	);

	// apb decode, zero wait states
	assign setup    = psel_in & ~penable_in;
	assign access   = psel_in & penable_in;
	assign hit_ctrl = (paddr_in == `MTC_OFFSET);
	assign hit_stat = (paddr_in == `STAT_OFFSET);
	assign wr_ctrl  = access & pwrite_in & hit_ctrl;
	assign pready_out  = 1'b1;
	assign pslverr_out = access & ~(hit_ctrl | hit_stat);

	// reserved bits never stored
	always @* begin
		ctrl_next = ctrl_reg;
		if (wr_ctrl)
			ctrl_next = pwdata_in & `MTC_WMASK;
	end

	// read data staged in the setup cycle
	always @* begin
		rdata_next = 32'h00000000;
		if (hit_ctrl)
			rdata_next = ctrl_reg & `MTC_WMASK;
		else if (hit_stat)
			rdata_next = {cfg_error_out, state_reg, ras_out,
				cas_out, 2'h0, act_count, rw_count, pre_count,
				xfer_mode_out, bus_width_out, 2'h0};
	end

	// register file
	always @(posedge clk_in) begin
		if (rst_in) begin
			ctrl_reg   <= `MTC_RESET;
			prdata_out <= 32'h00000000;
		end else begin
			ctrl_reg <= ctrl_next;
			if (setup)
				prdata_out <= rdata_next;
		end
	end

	// which commands may be taken now
	always @* begin
		case (cmd_code_in)
			`CMD_ACT: ready = (state_reg == ST_IDLE) & act_zero;
			`CMD_RD:  ready = (state_reg == ST_OPEN) & rw_zero;
			`CMD_WR:  ready = (state_reg == ST_OPEN) & rw_zero;
			`CMD_PRE: ready = (state_reg == ST_OPEN) & rw_zero &
				pre_zero;
			`CMD_REF: ready = (state_reg == ST_IDLE) & act_zero;
			default:  ready = 1'b0;
		endcase
	end

	assign cmd_ready_out = cmd_valid_in & ready;
	assign accept        = cmd_valid_in & ready;

	// command sequencer and timer loads
	always @* begin
		state_next = state_reg;
		ras_next   = ras_out;
		cas_next   = 1'b0;
		act_load   = 1'b0;
		act_value  = 6'h00;
		rw_load    = 1'b0;
		rw_value   = 6'h00;
		pre_load   = 1'b0;
		pre_value  = 6'h00;
		case (state_reg)
			ST_IDLE: begin
				if (accept && cmd_code_in == `CMD_ACT) begin
					state_next = ST_OPEN;
					ras_next   = 1'b1;
					rw_load    = 1'b1;
					// timer adds a cycle, load one less for exact delay
					rw_value   = rcd - 6'h01;
				end else if (accept && sdram_sel_in) begin
					act_load  = 1'b1;
					act_value = sdref;
				end else if (accept) begin
					state_next = ST_CBR;
					ras_next   = 1'b1;
					cas_next   = 1'b1;
					act_load   = 1'b1;
					act_value  = cbr - 6'h01;
				end
			end
			ST_OPEN: begin
				if (accept && cmd_code_in == `CMD_PRE) begin
					state_next = ST_IDLE;
					ras_next   = 1'b0;
					act_load   = 1'b1;
					act_value  = pre_gap;
				end else if (accept) begin
					cas_next = 1'b1;
					rw_load  = 1'b1;
					rw_value = cas_neg;
					if (cmd_code_in == `CMD_WR) begin
						pre_load  = 1'b1;
						pre_value = trwl;
					end
					// auto precharge closes the row itself
					if (sdram_sel_in && !row_hold_mode_select) begin
						state_next = ST_IDLE;
						ras_next   = 1'b0;
						act_load   = 1'b1;
						act_value  = pre_gap;
						if (cmd_code_in == `CMD_WR)
							act_value = pre_gap + trwl;
					end
				end
			end
			ST_CBR: begin
				cas_next = 1'b1;
				if (act_zero) begin
					state_next = ST_IDLE;
					ras_next   = 1'b0;
					cas_next   = 1'b0;
					act_load   = 1'b1;
					act_value  = ref_pre;
				end
			end
			default: begin
				state_next = ST_IDLE;
				ras_next   = 1'b0;
			end
		endcase
	end

	// strobe and state registers
	always @(posedge clk_in) begin
		if (rst_in) begin
			state_reg <= ST_IDLE;
			ras_out   <= 1'b0;
			cas_out   <= 1'b0;
		end else begin
			state_reg <= state_next;
			ras_out   <= ras_next;
			cas_out   <= cas_next;
		end
	end

	// decoded geometry and setting checks
	always @(posedge clk_in) begin
		if (rst_in) begin
			page_burst_out <= 1'b0;
			xfer_mode_out  <= MODE_SINGLE;
			bus_width_out  <= `SZ_64;
			col_bits_out   <= 4'h0;
			cfg_error_out  <= 1'b0;
		end else begin
			page_burst_out <= page_burst(mode, sz_code,
				xfer_size_in);
			xfer_mode_out  <= mode;
			bus_width_out  <= sz_code;
			col_bits_out   <= sdram_sel_in ? 4'h0 :
				{1'b0, amx_code} + 4'h8;
			cfg_error_out  <=
				(!sdram_sel_in && ctrl_reg[`EDO_BIT] &&
					!ctrl_reg[`BE_BIT]) ||
				(sz_code == `SZ_BAD) ||
				(sdram_sel_in && sz_code == `SZ_16) ||
				(!sdram_sel_in && (amx_code > 3'h4 ||
					ctrl_reg[`EXTENDED_MULTIPLEX_BIT_BIT])) ||
				(sdram_sel_in &&
					ctrl_reg[`RCD_LSB+1:`RCD_LSB] == 2'h0) ||
				(sdram_sel_in &&
					ctrl_reg[`TRWL_LSB+2:`TRWL_LSB] > 3'h4) ||
				(row_hold_mode_select && sdram_sel_in && (pre_gap > 6'h03 ||
					rcd > 6'h03 || trwl > 6'h02)) ||
				(row_hold_mode_select && !sdram_sel_in &&
					!ctrl_reg[`BE_BIT]);
		end
	end

endmodule

`default_nettype wire

// [tb/mem_timing_ctrl_asserts.sv]
`timescale 1ns/1ns
`default_nettype none
`include "mem_timing_map.vh"
module mem_timing_ctrl_asserts (
	input wire logic        clk_in,         // clock
	input wire logic        rst_in,         // reset
	input wire logic        psel_in,        // select
	input wire logic        penable_in,     // enable
	input wire logic        pwrite_in,      // write
	input wire logic [11:0] paddr_in,       // address
	input wire logic [31:0] pwdata_in,      // write data
	input wire logic [31:0] prdata_out,     // read data
	input wire logic        sdram_sel_in,   // sdram
	input wire logic [2:0]  xfer_size_in,   // size
	input wire logic        ras_out,        // row strobe
	input wire logic        cas_out,        // column strobe
	input wire logic        page_burst_out, // burst
	input wire logic [1:0]  xfer_mode_out,  // mode
	input wire logic [1:0]  bus_width_out,  // width
	input wire logic [3:0]  col_bits_out    // columns
);
	logic [31:0] sh_reg;
	logic [7:0]  hi_reg;
	logic [7:0]  lo_reg;
	wire         acc_w = psel_in && penable_in && paddr_in == 12'h000;
	wire         dram_w = !sdram_sel_in;
	wire [1:0]   mode_w = {sh_reg[9] & sh_reg[0], sh_reg[9] & ~sh_reg[0]};
	wire [1:0]   sz_w = sh_reg[8:7];
	wire         burst_w = xfer_size_in == 3'h4
		|| (xfer_size_in == 3'h3 && sz_w != 2'h0)
		|| (xfer_size_in == 3'h2 && sz_w == 2'h2);

	// shadow control word and strobe run lengths
	always @(posedge clk_in) begin
		if (rst_in) begin
			sh_reg <= 32'h00000000;
			hi_reg <= 8'h00;
			lo_reg <= 8'h00;
		end else begin
			if (acc_w && pwrite_in)
				sh_reg <= pwdata_in & `MTC_WMASK;
			hi_reg <= !ras_out ? 8'h00 : hi_reg + {7'h00, ~&hi_reg};
			lo_reg <= ras_out ? 8'h00 : lo_reg + {7'h00, ~&lo_reg};
		end
	end

	default clocking dc @(posedge clk_in);
	endclocking
	default disable iff (rst_in);

	a_rsvd_read_zero: assert property (
		acc_w && !pwrite_in |-> !(prdata_out & ~`MTC_WMASK))
		else $error("reserved bits read nonzero");
	a_cas_negate: assert property (
		$rose(cas_out) && $past(ras_out) && dram_w && sh_reg[23]
		|=> !cas_out [*2]) else $error("cas negation too short");
	a_ras_precharge: assert property (
		$rose(ras_out) && !cas_out && dram_w
		|-> lo_reg >= {5'h00, sh_reg[21:19]})
		else $error("ras precharge too short");
	a_ras_cas_delay: assert property (
		$rose(cas_out) && $past(ras_out) && dram_w
		|-> hi_reg >= 8'h02 + {6'h00, sh_reg[17:16]})
		else $error("ras to cas too short");
	a_cbr_width: assert property (
		$fell(ras_out) && $past(cas_out) && $past(cas_out, 2) && dram_w
		|-> hi_reg == 8'h02 + {5'h00, sh_reg[12:10]})
		else $error("refresh ras width wrong");
	a_sdram_burst: assert property (
		sdram_sel_in |=> xfer_mode_out == 2'h3)
		else $error("sdram mode not burst");
	a_dram_mode: assert property (
		dram_w && !(sh_reg[0] && !sh_reg[9])
		|=> xfer_mode_out == $past(mode_w))
		else $error("dram transfer mode wrong");
	a_page_burst: assert property (
		dram_w && mode_w == 2'h1 |=> page_burst_out == $past(burst_w))
		else $error("page burst decision wrong");
	a_bus_width: assert property (
		1'b1 |=> bus_width_out == $past(sz_w))
		else $error("bus width wrong");
	a_col_bits: assert property (
		dram_w && sh_reg[6:3] <= 4'h4
		|=> col_bits_out == 4'h8 + $past(sh_reg[6:3]))
		else $error("column bits wrong");

	c_cbr: cover property ($rose(ras_out) && $rose(cas_out));
	c_burst: cover property (page_burst_out);
	c_sdram: cover property (sdram_sel_in && $rose(ras_out));
endmodule
bind mem_timing_ctrl mem_timing_ctrl_asserts i_chk (.clk_in, .rst_in,
	.psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in,
	.prdata_out, .sdram_sel_in, .xfer_size_in, .ras_out, .cas_out,
	.page_burst_out, .xfer_mode_out, .bus_width_out, .col_bits_out);
`default_nettype wire

// [tb/dram_device_model.sv]
`timescale 1ns/1ns
`default_nettype none
module dram_device_model (
	input  wire logic       clk_in,     // bus clock
	input  wire logic       ras_in,     // row strobe
	output var  logic [7:0] lo_len_out, // last low run
	output var  logic [7:0] hi_len_out  // last high run
);
	logic [7:0] run_reg = 8'h00;
	logic       ras_reg = 1'b0;

	// time each run of the row strobe as the memory sees it
	always @(posedge clk_in) begin
		ras_reg <= ras_in;
		run_reg <= (ras_in == ras_reg) ? run_reg + 8'h01 : 8'h01;
		if (ras_in != ras_reg && ras_reg)
			hi_len_out <= run_reg;
		if (ras_in != ras_reg && !ras_reg)
			lo_len_out <= run_reg;
	end
endmodule
`default_nettype wire

// [tb/mem_timing_ctrl_tb_top.sv]
`timescale 1ns/1ns
`default_nettype none
`include "mem_timing_map.vh"
module mem_timing_ctrl_tb_top;
	logic        clk_in = 1'b0, rst_in = 1'b1, sdram_sel_in = 1'b0;
	logic        psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0;
	logic        cmd_valid_in = 1'b0;
	logic [2:0]  cmd_code_in = 3'h0, xfer_size_in = 3'h0;
	logic [11:0] paddr_in = 12'h000;
	logic [31:0] pwdata_in = 32'h00000000, rdat;
	wire  [31:0] prdata_out;
	wire         pready_out, pslverr_out, cmd_ready_out, ras_out;
	wire         cas_out, page_burst_out, cfg_error_out;
	wire  [1:0]  xfer_mode_out, bus_width_out;
	wire  [3:0]  col_bits_out;
	wire  [7:0]  lo_len, hi_len;
	logic        rerr;
	int          miscompares = 0, comparisons = 0, gap;

	mem_timing_ctrl i_dut (.clk_in, .rst_in, .psel_in, .penable_in,
		.pwrite_in, .paddr_in, .pwdata_in, .prdata_out, .pready_out,
		.pslverr_out, .sdram_sel_in, .cmd_valid_in, .cmd_code_in,
		.cmd_ready_out, .xfer_size_in, .ras_out, .cas_out,
		.page_burst_out, .xfer_mode_out, .bus_width_out,
		.col_bits_out, .cfg_error_out);
	dram_device_model i_mem (.clk_in, .ras_in(ras_out),
		.lo_len_out(lo_len), .hi_len_out(hi_len));

	// 125 MHz bus clock
	always #4 clk_in = ~clk_in;

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			miscompares++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic finish_test;
		$display("comparisons %0d miscompares %0d", comparisons,
			miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// one apb transfer, held until pready at an edge
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		@(posedge clk_in);
		psel_in <= 1'b1;
		pwrite_in <= w;
		paddr_in <= a;
		pwdata_in <= d;
		@(posedge clk_in);
		penable_in <= 1'b1;
		do @(posedge clk_in); while (pready_out !== 1'b1);
		rdat = prdata_out;
		rerr = pslverr_out;
		psel_in <= 1'b0;
		penable_in <= 1'b0;
		@(posedge clk_in);
	endtask

	// hold a command until taken; gap counts edges since the last one
	task automatic issue(input logic [2:0] c);
		logic ok;
		cmd_code_in <= c;
		cmd_valid_in <= 1'b1;
		gap = 0;
		do begin
			@(negedge clk_in);
			ok = cmd_ready_out;
			@(posedge clk_in);
			gap++;
		end while (ok !== 1'b1);
	endtask

	task automatic idle;
		cmd_valid_in <= 1'b0;
		repeat (2) @(negedge clk_in);
	endtask

	task automatic t_regs;
		apb(1'b0, 12'h000, 32'h00000000);
		chk(rdat, 32'h00000000);
		apb(1'b1, 12'h000, 32'hF8BBFFA7);
		apb(1'b0, 12'h000, 32'h00000000);
		chk(rdat, 32'hF8BBFFA7);
		apb(1'b0, 12'h004, 32'h00000000);
		chk(rdat, 32'h1000002C);
		apb(1'b0, 12'h008, 32'h00000000);
		chk(rerr, 1'b1);
		chk(rdat, 32'h00000000);
	endtask

	task automatic t_dram;
		apb(1'b1, 12'h000, 32'h089A8F10);
		@(negedge clk_in);
		chk({col_bits_out, bus_width_out, xfer_mode_out}, 8'hA9);
		chk(cfg_error_out, 1'b0);
		for (int i = 0; i < 5; i++) begin
			@(posedge clk_in);
			xfer_size_in <= 3'(i);
			@(posedge clk_in);
			@(negedge clk_in);
			chk(page_burst_out, i >= 2);
		end
		@(posedge clk_in);
		issue(`CMD_ACT);
		issue(`CMD_RD);
		chk(gap, 4);
		issue(`CMD_RD);
		chk(gap, 3);
		issue(`CMD_WR);
		issue(`CMD_PRE);
		chk(gap, 3);
		issue(`CMD_ACT);
		chk(gap, 4);
		issue(`CMD_PRE);
		issue(`CMD_REF);
		issue(`CMD_ACT);
		idle();
		chk(hi_len, 8'h05);
		chk(lo_len, 8'h04);
		@(posedge clk_in);
		issue(`CMD_PRE);
		idle();
	endtask

	task automatic t_sdram;
		apb(1'b1, 12'h000, 32'h08114580);
		sdram_sel_in <= 1'b1;
		@(posedge clk_in);
		@(negedge clk_in);
		chk({col_bits_out, xfer_mode_out}, 6'h03);
		@(posedge clk_in);
		issue(`CMD_ACT);
		issue(`CMD_WR);
		chk(gap, 2);
		issue(`CMD_ACT);
		chk(gap, 7);
		issue(`CMD_RD);
		issue(`CMD_ACT);
		chk(gap, 4);
		issue(`CMD_RD);
		idle();
		apb(1'b1, 12'h000, 32'h88092580);
		chk(cfg_error_out, 1'b0);
		issue(`CMD_ACT);
		issue(`CMD_WR);
		issue(`CMD_PRE);
		chk(gap, 3);
		issue(`CMD_REF);
		chk(gap, 3);
		issue(`CMD_ACT);
		chk(gap, 9);
		idle();
	endtask

	// main sequence
	initial begin
		repeat (5) @(posedge clk_in);
		rst_in <= 1'b0;
		t_regs();
		t_dram();
		t_sdram();
		finish_test();
	end

	// watchdog, far beyond the hundred-odd cycles the tests need
	initial begin
		#20000;
		miscompares++;
		finish_test();
	end
endmodule
`default_nettype wire
